/* ddrcd_pkg.sv */
package ddrcd_pkg;

    // Command code is {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MODE_SET  = 4'h0;
    localparam logic [3:0] CMD_REFRESH   = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
    localparam logic [3:0] CMD_WRITE     = 4'h4;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_NOP       = 4'h7;

    localparam int BANKS      = 8;
    localparam int BANK_W     = 3;
    localparam int ADDR_W     = 14;
    localparam int COL_W      = 10;

    // Fields of the address inputs
    localparam int PRE_ALL_POS  = 10;
    localparam int AUTO_PRE_POS = 10;

    // Mode register selectors on bank_sel
    localparam logic [2:0] MR_MAIN = 3'h0;
    localparam logic [2:0] MR_EXT1 = 3'h1;
    localparam logic [2:0] MR_EXT2 = 3'h2;
    localparam logic [2:0] MR_EXT3 = 3'h3;

    // Extended register one fields: termination select bits and mask/strobe select
    localparam int EMR_RTT_LO_POS  = 2;
    localparam int EMR_RTT_HI_POS  = 6;
    localparam int EMR_READ_ONLY_STROBE_POS    = 11;

    localparam logic [ADDR_W-1:0] EMR1_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] MR_RESET   = 14'h0000;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_PRE_DOWN,
        PWR_ACT_DOWN,
        PWR_SELF_REF
    } ddrcd_pwr_type;

endpackage

/* ddrcd_mask.sv */
`timescale 1ns/1ns
// Write-mask sampling: one mask value per clock in which either strobe edge is flagged
module ddrcd_mask (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       beat_rise,
    input  wire logic       beat_fall,
    input  wire logic       write_burst,
    input  wire logic       mask_mode,
    input  wire logic [1:0] write_mask,
    output logic      [1:0] store_en
);
    typedef struct packed {
        logic [1:0] store_en;
    } ddrcd_mask_st_type;

    ddrcd_mask_st_type st_q;
    ddrcd_mask_st_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.store_en = 2'h0;
        // Mask pin is only a mask when not set up as the read strobe
        if (write_burst && (beat_rise || beat_fall)) begin
            st_d.store_en = mask_mode ? ~write_mask : 2'h3;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign store_en = st_q.store_en;

    AST_MASK_DROP: assert property (@(posedge clk) disable iff (reset)
        (write_burst && beat_rise && mask_mode && write_mask[0]) |=> !store_en[0])
        else $error("Masked byte was stored");
    AST_MASK_EACH_EDGE: assert property (@(posedge clk) disable iff (reset)
        (write_burst && beat_fall && !write_mask[1]) |=> store_en[1])
        else $error("Unmasked beat on falling edge not stored");
endmodule

/* ddrcd_term.sv */
`timescale 1ns/1ns
// Termination gating for the data-side pins
module ddrcd_term (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       term_ctrl,
    input  wire logic       term_allowed,
    input  wire logic       term_rx_live,
    input  wire logic       wide_part,
    input  wire logic       read_only_strobe_on,
    output logic      [3:0] term_en
);
    // term_en: [0] data, [1] strobes, [2] masks / read strobe, [3] upper strobe
    typedef struct packed {
        logic [3:0] term_en;
    } ddrcd_term_st_type;

    ddrcd_term_st_type st_q;
    ddrcd_term_st_type st_d;
    logic              on;

    always_comb begin
        st_d = st_q;
        // Disabled termination means the pin is not even looked at
        on = term_allowed && term_rx_live && term_ctrl;
        st_d.term_en[0] = on;
        st_d.term_en[1] = on;
        st_d.term_en[2] = on;
        st_d.term_en[3] = on && (wide_part || read_only_strobe_on);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign term_en = st_q.term_en;

    AST_TERM_OFF_WHEN_DISABLED: assert property (@(posedge clk) disable iff (reset)
        !term_allowed |=> term_en == 4'h0)
        else $error("Termination applied while disabled");
    AST_TERM_ON: assert property (@(posedge clk) disable iff (reset)
        (term_allowed && term_rx_live && term_ctrl) |=> term_en[0] && term_en[1])
        else $error("Termination not applied");
endmodule

/* ddrcd_top.sv */
`timescale 1ns/1ns
module ddrcd_top (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         wide_part,
    input  wire logic                         clk_gate,
    input  wire logic                         rank_sel_n,
    input  wire logic                         row_strobe_n,
    input  wire logic                         col_strobe_n,
    input  wire logic                         write_strobe_n,
    input  wire logic [ddrcd_pkg::BANK_W-1:0] bank_sel,
    input  wire logic [ddrcd_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                         term_ctrl,
    input  wire logic                         beat_rise,
    input  wire logic                         beat_fall,
    input  wire logic                         write_burst,
    input  wire logic [1:0]                   write_mask,
    output logic      [ddrcd_pkg::BANKS-1:0]  bank_open,
    output logic      [ddrcd_pkg::BANK_W-1:0] cmd_bank,
    output logic      [ddrcd_pkg::ADDR_W-1:0] row_addr,
    output logic      [ddrcd_pkg::COL_W-1:0]  col_addr,
    output logic                              auto_pre,
    output logic                              rd_go,
    output logic                              wr_go,
    output logic                              refresh_go,
    output logic      [ddrcd_pkg::ADDR_W-1:0] mode_reg,
    output logic      [ddrcd_pkg::ADDR_W-1:0] ext_mode_reg_one,
    output logic      [ddrcd_pkg::ADDR_W-1:0] ext_mode_reg_two,
    output logic      [ddrcd_pkg::ADDR_W-1:0] ext_mode_reg_three,
    output logic      [1:0]                   pwr_state,
    output logic                              cmd_rx_live,
    output logic                              term_rx_live,
    output logic      [3:0]                   term_en,
    output logic      [1:0]                   store_en
);
    typedef struct packed {
        logic [ddrcd_pkg::BANKS-1:0]  bank_open;
        logic [ddrcd_pkg::BANK_W-1:0] cmd_bank;
        logic [ddrcd_pkg::ADDR_W-1:0] row_addr;
        logic [ddrcd_pkg::COL_W-1:0]  col_addr;
        logic                         auto_pre;
        logic                         rd_go;
        logic                         wr_go;
        logic                         refresh_go;
        logic [ddrcd_pkg::ADDR_W-1:0] mr;
        logic [ddrcd_pkg::ADDR_W-1:0] emr1;
        logic [ddrcd_pkg::ADDR_W-1:0] emr2;
        logic [ddrcd_pkg::ADDR_W-1:0] emr3;
        ddrcd_pkg::ddrcd_pwr_type     pwr;
        logic                         cmd_rx_live;
        logic                         term_rx_live;
    } ddrcd_st_type;

    ddrcd_st_type st_q;
    ddrcd_st_type st_d;
    logic [3:0]   cmd;
    logic         term_allowed;
    logic         self_ref_wake;

    // Termination is disabled when both resistor select bits are zero
    function automatic logic rtt_on(input logic [ddrcd_pkg::ADDR_W-1:0] emr);
        rtt_on = emr[ddrcd_pkg::EMR_RTT_LO_POS] | emr[ddrcd_pkg::EMR_RTT_HI_POS];
    endfunction

    function automatic logic [ddrcd_pkg::BANKS-1:0] bank_bit(
        input logic [ddrcd_pkg::BANK_W-1:0] b);
        bank_bit = ddrcd_pkg::BANKS'(1) << b;
    endfunction

    // Self-refresh exit waits one extra clock: clk_gate is registered into self_ref_wake first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            self_ref_wake <= 1'b0;
        end else begin
            self_ref_wake <= clk_gate;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.rd_go = 1'b0;
        st_d.wr_go = 1'b0;
        st_d.refresh_go = 1'b0;
        // Sampled each rising edge of the clock
        cmd = {rank_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
        term_allowed = rtt_on(st_q.emr1);
        unique case (st_q.pwr)
            ddrcd_pkg::PWR_ACTIVE: begin
                if (!clk_gate) begin
                    if (st_q.bank_open != '0) begin
                        st_d.pwr = ddrcd_pkg::PWR_ACT_DOWN;
                    end else if (cmd == ddrcd_pkg::CMD_REFRESH) begin
                        st_d.pwr = ddrcd_pkg::PWR_SELF_REF;
                    end else begin
                        st_d.pwr = ddrcd_pkg::PWR_PRE_DOWN;
                    end
                end else if (!rank_sel_n) begin
                    unique case (cmd)
                        ddrcd_pkg::CMD_ACTIVATE: begin
                            st_d.cmd_bank = bank_sel;
                            st_d.row_addr = addr_in;
                            st_d.bank_open = st_q.bank_open | bank_bit(bank_sel);
                        end
                        ddrcd_pkg::CMD_READ,
                        ddrcd_pkg::CMD_WRITE: begin
                            st_d.cmd_bank = bank_sel;
                            st_d.col_addr = addr_in[ddrcd_pkg::COL_W-1:0];
                            st_d.auto_pre = addr_in[ddrcd_pkg::AUTO_PRE_POS];
                            st_d.rd_go = (cmd == ddrcd_pkg::CMD_READ);
                            st_d.wr_go = (cmd == ddrcd_pkg::CMD_WRITE);
                            if (addr_in[ddrcd_pkg::AUTO_PRE_POS]) begin
                                st_d.bank_open = st_q.bank_open & ~bank_bit(bank_sel);
                            end
                        end
                        ddrcd_pkg::CMD_PRECHARGE: begin
                            st_d.cmd_bank = bank_sel;
                            if (addr_in[ddrcd_pkg::PRE_ALL_POS]) begin
                                st_d.bank_open = '0;
                            end else begin
                                st_d.bank_open = st_q.bank_open & ~bank_bit(bank_sel);
                            end
                        end
                        ddrcd_pkg::CMD_REFRESH: begin
                            st_d.refresh_go = 1'b1;
                        end
                        ddrcd_pkg::CMD_MODE_SET: begin
                            unique case (bank_sel)
                                ddrcd_pkg::MR_MAIN: st_d.mr   = addr_in;
                                ddrcd_pkg::MR_EXT1: st_d.emr1 = addr_in;
                                ddrcd_pkg::MR_EXT2: st_d.emr2 = addr_in;
                                ddrcd_pkg::MR_EXT3: st_d.emr3 = addr_in;
                                default: ;
                            endcase
                        end
                        default: ;
                    endcase
                end
            end
            ddrcd_pkg::PWR_PRE_DOWN,
            ddrcd_pkg::PWR_ACT_DOWN: begin
                // Commands are not decoded while powered down
                if (clk_gate) begin
                    st_d.pwr = ddrcd_pkg::PWR_ACTIVE;
                end
            end
            ddrcd_pkg::PWR_SELF_REF: begin
                if (self_ref_wake) begin
                    st_d.pwr = ddrcd_pkg::PWR_ACTIVE;
                end
            end
        endcase
        st_d.cmd_rx_live = (st_d.pwr == ddrcd_pkg::PWR_ACTIVE);
        st_d.term_rx_live = (st_d.pwr != ddrcd_pkg::PWR_SELF_REF);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.mr <= ddrcd_pkg::MR_RESET;
            st_q.emr1 <= ddrcd_pkg::EMR1_RESET;
            st_q.pwr <= ddrcd_pkg::PWR_ACTIVE;
            st_q.cmd_rx_live <= 1'b1;
            st_q.term_rx_live <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ddrcd_term u_term (
        .clk          (clk),
        .reset        (reset),
        .term_ctrl    (term_ctrl),
        .term_allowed (term_allowed),
        .term_rx_live (st_q.term_rx_live),
        .wide_part    (wide_part),
        .read_only_strobe_on      (st_q.emr1[ddrcd_pkg::EMR_READ_ONLY_STROBE_POS]),
        .term_en      (term_en)
    );

    // x16 parts always mask; x8 only when read strobe is not selected
    ddrcd_mask u_mask (
        .clk         (clk),
        .reset       (reset),
        .beat_rise   (beat_rise),
        .beat_fall   (beat_fall),
        .write_burst (write_burst && st_q.cmd_rx_live),
        .mask_mode   (wide_part || !st_q.emr1[ddrcd_pkg::EMR_READ_ONLY_STROBE_POS]),
        .write_mask  (write_mask),
        .store_en    (store_en)
    );

    assign bank_open          = st_q.bank_open;
    assign cmd_bank           = st_q.cmd_bank;
    assign row_addr           = st_q.row_addr;
    assign col_addr           = st_q.col_addr;
    assign auto_pre           = st_q.auto_pre;
    assign rd_go              = st_q.rd_go;
    assign wr_go              = st_q.wr_go;
    assign refresh_go         = st_q.refresh_go;
    assign mode_reg           = st_q.mr;
    assign ext_mode_reg_one   = st_q.emr1;
    assign ext_mode_reg_two   = st_q.emr2;
    assign ext_mode_reg_three = st_q.emr3;
    assign pwr_state          = st_q.pwr;
    assign cmd_rx_live        = st_q.cmd_rx_live;
    assign term_rx_live       = st_q.term_rx_live;

    AST_SELECT_MASKS: assert property (@(posedge clk) disable iff (reset)
        rank_sel_n |=> !rd_go && !wr_go && !refresh_go && $stable(ext_mode_reg_one))
        else $error("Command taken with select high");
    AST_READ_DECODE: assert property (@(posedge clk) disable iff (reset)
        (cmd_rx_live && clk_gate && cmd == ddrcd_pkg::CMD_READ)
        |=> rd_go && cmd_bank == $past(bank_sel))
        else $error("Read not decoded to its bank");
    AST_ACT_ROW: assert property (@(posedge clk) disable iff (reset)
        (cmd_rx_live && clk_gate && cmd == ddrcd_pkg::CMD_ACTIVATE)
        |=> row_addr == $past(addr_in) && bank_open[cmd_bank])
        else $error("Activate did not capture row");
    AST_PRE_ALL: assert property (@(posedge clk) disable iff (reset)
        (cmd_rx_live && clk_gate && cmd == ddrcd_pkg::CMD_PRECHARGE
         && addr_in[ddrcd_pkg::PRE_ALL_POS]) |=> bank_open == '0)
        else $error("Precharge all left a bank open");
    AST_MRS_EXT1: assert property (@(posedge clk) disable iff (reset)
        (cmd_rx_live && clk_gate && cmd == ddrcd_pkg::CMD_MODE_SET
         && bank_sel == ddrcd_pkg::MR_EXT1)
        |=> ext_mode_reg_one == $past(addr_in) && $stable(mode_reg))
        else $error("Extended register one not loaded");
    AST_PD_ACTIVE: assert property (@(posedge clk) disable iff (reset)
        (cmd_rx_live && !clk_gate && bank_open != '0)
        |=> pwr_state == 2'(ddrcd_pkg::PWR_ACT_DOWN) && !cmd_rx_live)
        else $error("Active power-down not entered");
    AST_SR_RX_OFF: assert property (@(posedge clk) disable iff (reset)
        pwr_state == 2'(ddrcd_pkg::PWR_SELF_REF) |-> !cmd_rx_live && !term_rx_live)
        else $error("Receivers live in self refresh");
    AST_SR_EXIT: assert property (@(posedge clk) disable iff (reset)
        (pwr_state == 2'(ddrcd_pkg::PWR_SELF_REF) && clk_gate)
        |-> ##[1:2] pwr_state == 2'(ddrcd_pkg::PWR_ACTIVE))
        else $error("Self refresh not left");

    COV_WRITE: cover property (@(posedge clk) disable iff (reset) wr_go);
    COV_SELF_REF: cover property (@(posedge clk) disable iff (reset)
        pwr_state == 2'(ddrcd_pkg::PWR_SELF_REF));
    COV_ACT_DOWN: cover property (@(posedge clk) disable iff (reset)
        pwr_state == 2'(ddrcd_pkg::PWR_ACT_DOWN));
    COV_TERM: cover property (@(posedge clk) disable iff (reset) term_en[0]);
endmodule

/* ddrcd_ctrl_model.sv */
`timescale 1ns/1ns
// Controller side of the command pins; changes pins on the falling edge
module ddrcd_ctrl_model (
    input  wire logic                         clk,
    output logic                              clk_gate,
    output logic                              rank_sel_n,
    output logic                              row_strobe_n,
    output logic                              col_strobe_n,
    output logic                              write_strobe_n,
    output logic      [ddrcd_pkg::BANK_W-1:0] bank_sel,
    output logic      [ddrcd_pkg::ADDR_W-1:0] addr_in,
    output logic                              term_ctrl
);
    initial begin
        clk_gate = 1'b1;
        {rank_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} = ddrcd_pkg::CMD_NOP;
        bank_sel = 3'h0;
        addr_in = 14'h0000;
        term_ctrl = 1'b0;
    end

    // One command per cycle, held on the pins until the next call to issue
    task automatic issue(input logic g, input logic [3:0] c, input logic [2:0] b,
                         input logic [13:0] a);
        @(negedge clk);
        clk_gate <= g;
        {rank_sel_n, row_strobe_n, col_strobe_n, write_strobe_n} <= c;
        bank_sel <= b;
        // Idle address flips so stale values never look valid
        addr_in <= (c == ddrcd_pkg::CMD_NOP) ? ~addr_in : a;
    endtask

    task automatic term(input logic v);
        term_ctrl <= v;
    endtask
endmodule

/* test_sdram_pin_command_decode.sv */
`timescale 1ns/1ns
module test_sdram_pin_command_decode;
    typedef struct {int sel; logic [31:0] exp; int due;} ddrcd_note_type;
    localparam logic [3:0] MODE_SET_CMD = ddrcd_pkg::CMD_MODE_SET;
    localparam logic [3:0] REF = ddrcd_pkg::CMD_REFRESH;
    localparam logic [3:0] PRE = ddrcd_pkg::CMD_PRECHARGE;
    localparam logic [3:0] ACT = ddrcd_pkg::CMD_ACTIVATE;
    localparam logic [3:0] WR  = ddrcd_pkg::CMD_WRITE;
    localparam logic [3:0] RD  = ddrcd_pkg::CMD_READ;
    localparam logic [3:0] NOP = ddrcd_pkg::CMD_NOP;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        wide_part = 1'b0;
    logic        beat_rise = 1'b0;
    logic        beat_fall = 1'b0;
    logic        write_burst = 1'b0;
    logic [1:0]  write_mask = 2'h0;
    logic        clk_gate, rank_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, term_ctrl;
    logic [2:0]  bank_sel, cmd_bank;
    logic [13:0] addr_in, row_addr, mode_reg, emr1, emr2, emr3;
    logic [7:0]  bank_open;
    logic [9:0]  col_addr;
    logic        auto_pre, rd_go, wr_go, refresh_go, cmd_rx_live, term_rx_live;
    logic [1:0]  pwr_state, store_en;
    logic [3:0]  term_en;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;
    ddrcd_note_type notes[$];
    string names[17] = '{"bank_open", "cmd_bank", "row_addr", "col_addr", "auto_pre", "rd_go",
        "wr_go", "refresh_go", "mode_reg", "ext_mode_reg_one", "ext_mode_reg_two",
        "ext_mode_reg_three", "pwr_state", "cmd_rx_live", "term_rx_live", "term_en", "store_en"};

    always #5 clk = ~clk;

    ddrcd_ctrl_model m (.clk(clk), .clk_gate(clk_gate), .rank_sel_n(rank_sel_n),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_strobe_n(write_strobe_n), .bank_sel(bank_sel), .addr_in(addr_in),
        .term_ctrl(term_ctrl));

    ddrcd_top dut (.clk(clk), .reset(reset), .wide_part(wide_part), .clk_gate(clk_gate),
        .rank_sel_n(rank_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_strobe_n(write_strobe_n), .bank_sel(bank_sel), .addr_in(addr_in),
        .term_ctrl(term_ctrl), .beat_rise(beat_rise), .beat_fall(beat_fall),
        .write_burst(write_burst), .write_mask(write_mask), .bank_open(bank_open),
        .cmd_bank(cmd_bank), .row_addr(row_addr), .col_addr(col_addr), .auto_pre(auto_pre),
        .rd_go(rd_go), .wr_go(wr_go), .refresh_go(refresh_go), .mode_reg(mode_reg),
        .ext_mode_reg_one(emr1), .ext_mode_reg_two(emr2), .ext_mode_reg_three(emr3),
        .pwr_state(pwr_state), .cmd_rx_live(cmd_rx_live), .term_rx_live(term_rx_live),
        .term_en(term_en), .store_en(store_en));

    function automatic logic [31:0] seen(input int s);
        case (s)
            0: return 32'(bank_open);
            1: return 32'(cmd_bank);
            2: return 32'(row_addr);
            3: return 32'(col_addr);
            4: return 32'(auto_pre);
            5: return 32'(rd_go);
            6: return 32'(wr_go);
            7: return 32'(refresh_go);
            8: return 32'(mode_reg);
            9: return 32'(emr1);
            10: return 32'(emr2);
            11: return 32'(emr3);
            12: return 32'(pwr_state);
            13: return 32'(cmd_rx_live);
            14: return 32'(term_rx_live);
            15: return 32'(term_en);
            default: return 32'(store_en);
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic note(input int s, input logic [31:0] e, input int d = 1);
        notes.push_back('{s, e, cyc + d});
    endtask

    task automatic c(input logic [3:0] k, input logic [2:0] b, input logic [13:0] a,
                     input logic g = 1'b1);
        m.issue(g, k, b, a);
    endtask

    task automatic beat(input logic r, input logic f, input logic [1:0] mk);
        @(negedge clk);
        write_burst <= 1'b1;
        beat_rise <= r;
        beat_fall <= f;
        write_mask <= mk;
    endtask

    // Results are taken off the queue once their cycle has come
    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            check(names[notes[0].sel], seen(notes[0].sel), notes[0].exp);
            void'(notes.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 1000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        logic [13:0] op, row;
        logic [9:0]  col;
        logic [2:0]  b;
        logic [1:0]  mk;
        void'($urandom(84));
        repeat (5) @(negedge clk);
        reset = 1'b0;
        note(12, 0); note(13, 1); note(14, 1); note(0, 0); note(15, 0); note(16, 0);
        for (int i = 0; i < 4; i++) begin
            op = 14'($urandom);
            // Register one: termination on, mask mode
            if (i == 1) op = (op & 14'h37BB) | 14'h0004;
            c(MODE_SET_CMD, 3'(i), op);
            note(8 + i, 32'(op));
        end
        b = 3'($urandom);
        row = 14'($urandom);
        col = 10'($urandom);
        c(ACT, b, row);
        note(0, 32'h1 << b); note(1, 32'(b)); note(2, 32'(row));
        c(RD, b, {4'h0, col});
        note(5, 1); note(3, 32'(col)); note(4, 0);
        c(WR, b, {4'h1, col});
        note(6, 1); note(5, 0); note(4, 1); note(0, 0);
        c(4'hB, ~b, row);
        note(0, 0); note(1, 32'(b));
        c(ACT, 3'h1, row);
        c(ACT, 3'h6, row);
        note(0, 32'h42);
        c(PRE, 3'h6, 14'h0000);
        note(0, 32'h02); note(1, 6);
        c(PRE, 3'h0, 14'h0400);
        note(0, 0);
        c(REF, 3'h0, 14'h0000);
        note(7, 1);
        c(NOP, 3'h0, 14'h0000);
        m.term(1'b1);
        note(15, 32'h7);
        c(MODE_SET_CMD, 3'h1, 14'h0800);
        m.term(1'b0);
        note(9, 32'h0800); note(15, 0);
        c(NOP, 3'h0, 14'h0000);
        m.term(1'b1);
        note(15, 0);
        c(MODE_SET_CMD, 3'h1, 14'h0840);
        c(NOP, 3'h0, 14'h0000);
        note(15, 32'hF);
        mk = 2'($urandom);
        beat(1'b1, 1'b1, mk);
        note(16, 3);
        c(MODE_SET_CMD, 3'h1, 14'h0004);
        for (int i = 0; i < 4; i++) begin
            mk = 2'($urandom);
            beat(1'b1, 1'b1, mk);
            note(16, 32'(mk ^ 2'h3));
        end
        beat(1'b1, 1'b0, 2'h1);
        note(16, 2);
        beat(1'b0, 1'b0, 2'h0);
        note(16, 0);
        c(NOP, 3'h0, 14'h0000, 1'b0);
        note(12, 1); note(13, 0); note(14, 1);
        c(ACT, 3'h3, row, 1'b0);
        note(0, 0); note(15, 32'h7);
        c(NOP, 3'h0, 14'h0000);
        note(12, 0);
        c(ACT, 3'h3, row);
        note(0, 32'h08);
        c(NOP, 3'h0, 14'h0000, 1'b0);
        note(12, 2);
        c(NOP, 3'h0, 14'h0000);
        note(12, 0);
        c(PRE, 3'h0, 14'h0400);
        note(0, 0);
        c(REF, 3'h0, 14'h0000, 1'b0);
        note(12, 3); note(13, 0); note(14, 0);
        c(NOP, 3'h0, 14'h0000, 1'b0);
        note(15, 0);
        beat(1'b1, 1'b1, 2'h0);
        note(16, 0);
        c(NOP, 3'h0, 14'h0000);
        note(12, 0, 2);
        repeat (4) @(negedge clk);
        results();
    end
endmodule
